// ### rtl/tbc_pkg.sv
package tbc_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;

  // control register fields
  localparam int CTRL_START_BIT = 0;

  // mode register fields
  localparam int MODE_SEL_LSB = 0;
  localparam int EDGE_LSB     = 2;
  localparam int SRC_BIT      = 4;
  localparam int OVF_BIT      = 5;
  localparam int CLK_LSB      = 6;
  localparam logic [7:0] MODE_WMASK = 8'hdf;

  // operating modes
  localparam logic [1:0] MD_TIMER = 2'h0;
  localparam logic [1:0] MD_EVENT = 2'h1;
  localparam logic [1:0] MD_MEAS  = 2'h2;

  // edge select: event edges, or period (rise/fall) and width (both)
  localparam logic [1:0] EDG_RISE = 2'h0;
  localparam logic [1:0] EDG_FALL = 2'h1;
  localparam logic [1:0] EDG_BOTH = 2'h2;

  // count clock select
  localparam logic [1:0] CK_DIV1   = 2'h0;
  localparam logic [1:0] CK_DIV8   = 2'h1;
  localparam logic [1:0] CK_DIV32  = 2'h2;
  localparam logic [1:0] CK_SUB32  = 2'h3;
  localparam logic [4:0] PRE8_LAST  = 5'h07;
  localparam logic [4:0] PRE32_LAST = 5'h1f;

  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hffff;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] rld;
    logic        start;
    logic [7:0]  mode;
    logic        ovf;
    logic        armed;
    logic        pin_d;
    logic [4:0]  pre;
    logic [4:0]  sub;
    logic        irq;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tbc_st_t;

  localparam tbc_st_t ST_RST = '0;

endpackage

// ### rtl/tbc_channel.sv
// Overview of operation
// - mode register bits 1:0 pick timer, event counter or measurement
// - timer mode counts clock divided by 1, 8, 32 or subclock divided by 32
// - timer and event modes count down, reload and request interrupt on underflow
// - underflow every set value plus one count periods
// - counting only while the start flag is 1
// - timer mode data read returns the live counter
// - data write while stopped loads reload register and counter
// - data write while counting loads reload register only
// - event mode counts pin edges or another timer's overflow
// - event edge selectable rising, falling or both
// - event mode data read returns the counter
// - measurement mode counts up on prescaled clock
// - valid edge copies counter to reload register and clears counter
// - each valid edge requests interrupt except the first after start
// - measurement overflow requests interrupt and sets overflow flag
// - mode register write while started clears overflow flag
// - measurement data read returns the reload register
// - measurement result undefined until second valid edge after start
// - measurement mode ignores data writes
`timescale 1ns/1ps
`default_nettype none

module tbc_channel
  import tbc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        pulse_input_pin,
  input  wire logic        ext_ovf_in,
  input  wire logic        subclk_tick,
  output logic             irq_req,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       now_v,
                                    input logic       prev_v);
    logic res;
    res = 1'b0;
    case (sel)
      EDG_RISE: res = now_v & ~prev_v;
      EDG_FALL: res = ~now_v & prev_v;
      EDG_BOTH: res = now_v ^ prev_v;
      default:  res = 1'b0;
    endcase
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync_r;
  logic       rst_sync_b;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_sync_b = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // state and decode

  tbc_st_t     st_r;
  tbc_st_t     st_nxt;
  logic [1:0]  md;
  logic [1:0]  esel;
  logic [1:0]  csel;
  logic        tick;
  logic        ev;
  logic        dn_en;
  logic        meas_edge;
  logic        meas_tick;
  logic        wr_go;
  logic        wr_ctrl;
  logic        wr_mode;
  logic        wr_data;
  logic        rd_go;
  logic [31:0] wr_val;
  logic [7:0]  mode_rd;
  logic [31:0] mode_mrg;
  logic [31:0] rld_mrg;
  logic [31:0] cnt_mrg;

  // mode select
  // mode field decode
  assign md   = st_r.mode[MODE_SEL_LSB +: 2];
  assign esel = st_r.mode[EDGE_LSB +: 2];
  assign csel = st_r.mode[CLK_LSB +: 2];

  always_comb begin
    case (csel)
      CK_DIV1:  tick = 1'b1;
      CK_DIV8:  tick = (st_r.pre[2:0] == PRE8_LAST[2:0]);
      CK_DIV32: tick = (st_r.pre == PRE32_LAST);
      default:  tick = subclk_tick & (st_r.sub == PRE32_LAST);
    endcase
  end

  assign ev = st_r.mode[SRC_BIT] ? ext_ovf_in
                                 : edge_hit(esel, pulse_input_pin, st_r.pin_d);

  assign dn_en = st_r.start &
                 (((md == MD_TIMER) & tick) | ((md == MD_EVENT) & ev));

  assign meas_edge = st_r.start & (md == MD_MEAS) &
                     edge_hit(esel, pulse_input_pin, st_r.pin_d);
  assign meas_tick = st_r.start & (md == MD_MEAS) & tick;

  assign wr_go   = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
  assign wr_ctrl = wr_go & (st_r.awaddr == ADDR_CTRL);
  assign wr_mode = wr_go & (st_r.awaddr == ADDR_MODE);
  assign wr_data = wr_go & (st_r.awaddr == ADDR_DATA);
  assign wr_val  = st_r.wdata;
  assign rd_go   = s_axi_arvalid & s_axi_arready;
  assign mode_rd = {st_r.mode[7:6], st_r.ovf, st_r.mode[4:0]};
  assign mode_mrg = merge({24'h0, st_r.mode}, wr_val, st_r.wstrb);
  assign rld_mrg  = merge({16'h0, st_r.rld}, wr_val, st_r.wstrb);
  assign cnt_mrg  = merge({16'h0, st_r.cnt}, wr_val, st_r.wstrb);

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt     = st_r;
    st_nxt.irq = 1'b0;
    st_nxt.pin_d = pulse_input_pin;
    st_nxt.pre = st_r.pre + 5'h01;
    if (subclk_tick) begin
      st_nxt.sub = st_r.sub + 5'h01;
    end

    // write channels
    if (s_axi_awvalid & s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid & s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = (wr_ctrl | wr_mode | wr_data) ? RESP_OKAY : RESP_SLVERR;
    end

    if (wr_ctrl & st_r.wstrb[0]) begin
      st_nxt.start = wr_val[CTRL_START_BIT];
      if (wr_val[CTRL_START_BIT] & ~st_r.start) begin
        st_nxt.armed = 1'b0;
      end
    end
    if (wr_mode) begin
      st_nxt.mode = mode_mrg[7:0] & MODE_WMASK;
      // overflow flag cleared by mode write while started
      if (st_r.start) begin
        st_nxt.ovf = 1'b0;
      end
    end
    if (wr_data & (md != MD_MEAS)) begin
      // reload register always takes the write
      st_nxt.rld = rld_mrg[15:0];
      if (~st_r.start) begin
        st_nxt.cnt = cnt_mrg[15:0];
      end
    end

    // down count with reload on underflow
    if (dn_en) begin
      if (st_r.cnt == CNT_ZERO) begin
        st_nxt.cnt = st_r.rld;
        st_nxt.irq = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - 16'h0001;
      end
    end

    if (meas_edge) begin
      st_nxt.rld   = st_r.cnt;
      st_nxt.cnt   = CNT_ZERO;
      st_nxt.armed = 1'b1;
      st_nxt.irq   = st_r.armed;
    end else if (meas_tick) begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
      if (st_r.cnt == CNT_MAX) begin
        st_nxt.ovf = 1'b1;
        st_nxt.irq = 1'b1;
      end
    end

    // read channel
    if (s_axi_rvalid & s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      if (s_axi_araddr == ADDR_CTRL) begin
        st_nxt.rdata = {31'h0, st_r.start};
      end else if (s_axi_araddr == ADDR_MODE) begin
        st_nxt.rdata = {24'h0, mode_rd};
      end else if (s_axi_araddr == ADDR_DATA) begin
        st_nxt.rdata = {16'h0, (md == MD_MEAS) ? st_r.rld : st_r.cnt};
      end else begin
        st_nxt.rdata = 32'h0;
        st_nxt.rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign irq_req       = st_r.irq;
  assign s_axi_awready = ~st_r.aw_got & ~st_r.bvalid;
  assign s_axi_wready  = ~st_r.w_got & ~st_r.bvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = ~st_r.rvalid;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_sync_b);

  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence s_wr_resp;
    ##2 s_axi_bvalid;
  endsequence

  a_write_resp: assert property (s_wr_both |-> s_wr_resp)
    else $error("write response not two cycles after address and data");

  a_stopped_hold: assert property (
    !st_r.start && !wr_data |=> $stable(st_r.cnt))
    else $error("counter moved while stopped");

  a_under_reload: assert property (
    dn_en && st_r.cnt == CNT_ZERO |=> st_r.cnt == $past(st_r.rld) && irq_req)
    else $error("underflow without reload and request");

  a_down_step: assert property (
    dn_en && st_r.cnt != CNT_ZERO |=> st_r.cnt == $past(st_r.cnt) - 16'h0001)
    else $error("down count step wrong");

  a_run_write: assert property (
    wr_data && st_r.start && md != MD_MEAS && !dn_en && st_r.wstrb == 4'hf
    |=> st_r.rld == $past(wr_val[15:0]) && $stable(st_r.cnt))
    else $error("running write touched counter");

  a_stop_write: assert property (
    wr_data && !st_r.start && md != MD_MEAS && st_r.wstrb == 4'hf
    |=> st_r.cnt == $past(wr_val[15:0]) && st_r.rld == $past(wr_val[15:0]))
    else $error("stopped write did not load both");

  a_meas_capture: assert property (
    meas_edge |=> st_r.cnt == CNT_ZERO && st_r.rld == $past(st_r.cnt))
    else $error("capture wrong on valid edge");

  a_first_quiet: assert property (
    meas_edge && !st_r.armed |=> !irq_req ##1 st_r.armed)
    else $error("first edge raised a request");

  a_ovf_set: assert property (
    meas_tick && !meas_edge && st_r.cnt == CNT_MAX |=> st_r.ovf && irq_req)
    else $error("overflow without flag and request");

  a_ovf_clear: assert property (
    wr_mode && st_r.start && !(meas_tick && st_r.cnt == CNT_MAX) |=> !st_r.ovf)
    else $error("overflow flag not cleared");

  a_meas_nowrite: assert property (
    wr_data && md == MD_MEAS && !meas_edge |=> $stable(st_r.rld))
    else $error("measurement reload changed by write");

  a_stop_quiet: assert property (
    !st_r.start |=> !irq_req)
    else $error("request raised while stopped");

  a_up_step: assert property (
    meas_tick && !meas_edge |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
    else $error("up count step wrong");

  a_edge_request: assert property (
    meas_edge && st_r.armed |=> irq_req)
    else $error("armed edge raised no request");

  a_start_disarm: assert property (
    wr_ctrl && st_r.wstrb[0] && wr_val[CTRL_START_BIT] && !st_r.start |=> !st_r.armed)
    else $error("start did not clear first edge memory");

  a_meas_read: assert property (
    rd_go && s_axi_araddr == ADDR_DATA && md == MD_MEAS |=> s_axi_rdata == {16'h0, $past(st_r.rld)})
    else $error("measurement read not from reload register");

  a_count_read: assert property (
    rd_go && s_axi_araddr == ADDR_DATA && md != MD_MEAS |=> s_axi_rdata == {16'h0, $past(st_r.cnt)})
    else $error("count read not from counter");

  a_event_ext: assert property (
    st_r.start && md == MD_EVENT && st_r.mode[SRC_BIT] && ext_ovf_in |-> dn_en)
    else $error("external overflow not counted");

  a_div8_space: assert property (
    dn_en && md == MD_TIMER && csel == CK_DIV8 |=> !dn_en [*7])
    else $error("divide by 8 tick too early");

endmodule

`default_nettype wire

// ### sim/tbc_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none

module tbc_pulse_src (
  input  wire logic sys_clk,
  output logic      pin
);

  // line idles low like a pulled-down input
  initial pin = 1'b0;

  // k high pulses, each after lo low cycles, hi cycles wide
  task automatic burst(input int k, input int hi, input int lo);
    for (int i = 0; i < k; i++) begin
      repeat (lo) @(posedge sys_clk);
      pin <= 1'b1;
      repeat (hi) @(posedge sys_clk);
      pin <= 1'b0;
    end
  endtask

endmodule

`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import tbc_pkg::*;
;

  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        pin;
  logic        ext_ovf_in = 1'b0;
  logic        subclk_tick = 1'b0;
  logic        irq_req;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready;
  logic        s_axi_wready;
  logic        s_axi_bvalid;
  logic        s_axi_arready;
  logic        s_axi_rvalid;
  logic [1:0]  s_axi_bresp;
  logic [1:0]  s_axi_rresp;
  logic [1:0]  rs;
  int          num_errors = 0;
  int          checks_done = 0;
  int          irq_cnt = 0;

  tbc_channel i_dut (.sys_clk, .rst_b, .pulse_input_pin(pin), .ext_ovf_in, .subclk_tick, .irq_req,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  tbc_pulse_src i_src (.sys_clk, .pin);

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) subclk_tick <= ~subclk_tick;
  always @(posedge sys_clk) if (irq_req === 1'b1) irq_cnt <= irq_cnt + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic int exp_gap(input int n, input int d);
    return (n + 1) * d;
  endfunction

  function automatic int exp_event(input int e, input int k);
    return 50 - ((e == int'(EDG_BOTH)) ? 2 * k : k);
  endfunction

  // cycles between two interrupt pulses
  task automatic gap(output int g);
    int c;
    c = irq_cnt;
    repeat (2000) begin
      @(posedge sys_clk);
      if (irq_cnt != c) break;
    end
    c = irq_cnt;
    g = 0;
    repeat (2000) begin
      @(posedge sys_clk);
      g++;
      if (irq_cnt != c) break;
    end
  endtask

  initial begin
    #2400000;
    num_errors++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic [31:0] w;
    int          n;
    int          g;
    int          k;
    int          e;
    int          c;
    int          dv[4] = '{1, 8, 32, 64};
    v = $urandom(32'hc2ffaab2);
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (k = 0; k < 3; k++) begin
      rd(8'(4 * k), v);
      chk("reset_value", 32'h0, v);
    end
    rd(8'h0c, v);
    chk("unmapped_rresp", 32'(RESP_SLVERR), 32'(rs));
    wr(8'h0c, 32'h5);
    chk("unmapped_bresp", 32'(RESP_SLVERR), 32'(rs));
    $display("test registers done");
    for (k = 0; k < 4; k++) begin
      n = $urandom_range(4, 1);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_MODE, 32'(k) << CLK_LSB);
      wr(ADDR_DATA, 32'(n));
      rd(ADDR_DATA, v);
      chk("load_stopped", 32'(n), v);
      wr(ADDR_CTRL, 32'h1);
      gap(g);
      gap(g);
      chk("underflow_gap", 32'(exp_gap(n, dv[k])), 32'(g));
    end
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_MODE, 32'h0);
    wr(ADDR_DATA, 32'd100);
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_DATA, v);
    rd(ADDR_DATA, w);
    chk("live_count", 32'h1, 32'(v != w));
    wr(ADDR_DATA, 32'h3);
    rd(ADDR_DATA, v);
    chk("run_write_no_load", 32'h1, 32'(v > 3));
    gap(g);
    gap(g);
    chk("reload_next_period", 32'h4, 32'(g));
    wr(ADDR_CTRL, 32'h0);
    repeat (2) @(posedge sys_clk);
    c = irq_cnt;
    rd(ADDR_DATA, v);
    repeat (40) @(posedge sys_clk);
    rd(ADDR_DATA, w);
    chk("stop_holds", v, w);
    chk("stop_no_irq", 32'(c), 32'(irq_cnt));
    $display("test timer done");
    for (e = 0; e < 4; e++) begin
      k = $urandom_range(5, 1);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_MODE, 32'(MD_EVENT) | (e == 3 ? 32'h1 << SRC_BIT : 32'(e) << EDGE_LSB));
      wr(ADDR_DATA, 32'd50);
      wr(ADDR_CTRL, 32'h1);
      if (e == 3) begin
        repeat (k) begin
          @(posedge sys_clk);
          ext_ovf_in <= 1'b1;
          @(posedge sys_clk);
          ext_ovf_in <= 1'b0;
        end
      end else begin
        i_src.burst(k, $urandom_range(4, 1), $urandom_range(4, 2));
      end
      repeat (4) @(posedge sys_clk);
      rd(ADDR_DATA, v);
      chk("event_count", 32'(exp_event(e, k)), v);
    end
    $display("test event done");
    n = $urandom_range(12, 6);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_MODE, 32'(MD_MEAS) | 32'(EDG_RISE) << EDGE_LSB);
    wr(ADDR_CTRL, 32'h1);
    c = irq_cnt;
    i_src.burst(3, 3, n - 3);
    repeat (4) @(posedge sys_clk);
    chk("period_irqs", 32'(c + 2), 32'(irq_cnt));
    rd(ADDR_DATA, v);
    chk("period_capture", 32'(n - 1), v);
    wr(ADDR_DATA, 32'h7);
    rd(ADDR_DATA, w);
    chk("meas_write_ignored", v, w);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_MODE, 32'(MD_MEAS) | 32'(EDG_BOTH) << EDGE_LSB);
    wr(ADDR_CTRL, 32'h1);
    c = irq_cnt;
    i_src.burst(2, n, 4);
    repeat (4) @(posedge sys_clk);
    chk("width_irqs", 32'(c + 3), 32'(irq_cnt));
    rd(ADDR_DATA, v);
    chk("width_capture", 32'(n - 1), v);
    $display("test measure done");
    c = irq_cnt;
    repeat (70000) begin
      @(posedge sys_clk);
      if (irq_cnt != c) break;
    end
    rd(ADDR_MODE, v);
    chk("ovf_set", 32'h1, 32'(v[OVF_BIT]));
    chk("ovf_irq", 32'(c + 1), 32'(irq_cnt));
    wr(ADDR_MODE, 32'(MD_MEAS) | 32'(EDG_BOTH) << EDGE_LSB);
    rd(ADDR_MODE, v);
    chk("ovf_clear", 32'h0, 32'(v[OVF_BIT]));
    $display("test overflow done");
    close_out();
  end

endmodule

`default_nettype wire
